// ### sram_port_pkg.sv
// constants, types and decode helpers shared by the pipelined burst sram port
// How it works
// - every synchronous input sampled on rising edge
// - read or write data two cycles after address
// - suspend high freezes inputs and all state
// - deselect on load stops burst, no new access
// - accesses already in pipeline still complete
// - bus released two cycles after deselect or write
// - four-beat burst from one address, 2-bit counter
// - strap picks linear or interleaved burst order
// - load low loads address, high advances counter
// - output enable and strap act without clock
// - each byte lane has own low write enable
// - reads and writes mix back to back freely
// - one read/write strobe sampled at access start
// - array holds 512K x 36 or 1M x 18
// - read data leaves through an output register
package sram_port_pkg;

    // ------------------------------------------------------------
    // organization
    // ------------------------------------------------------------
    localparam int LANE_DATA_BITS = 8;
    localparam int LANE_BITS      = 9;
    localparam int LANES_WIDE     = 4;
    localparam int LANES_NARROW   = 2;
    localparam int ADDR_W_WIDE    = 19;
    localparam int ADDR_W_NARROW  = 20;
    localparam int DEPTH_WIDE     = 524288;
    localparam int DEPTH_NARROW   = 1048576;
    localparam int BEAT_W         = 2;
    localparam int MAX_LANES      = 4;

    // ------------------------------------------------------------
    // values after reset
    // ------------------------------------------------------------
    localparam logic [1:0] BEAT_RESET  = 2'h0;
    localparam logic       VALID_RESET = 1'h0;
    localparam logic       DRIVE_RESET = 1'h0;

    typedef enum logic {
        BURST_IDLE,
        BURST_RUN
    } burst_state_t;

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    function automatic logic device_selected(input logic selANeg,
                                             input logic selB,
                                             input logic selCNeg);
        device_selected = !selANeg && selB && !selCNeg;
    endfunction : device_selected

endpackage : sram_port_pkg

// ### burst_sequencer.sv
// burst order generator for the two low address bits
`timescale 1ns/10ps
module burst_sequencer (
    input  wire logic [1:0] startLow,
    input  wire logic [1:0] beat,
    input  wire logic       interleaved,
    output logic      [1:0] orderedLow
);
    import sram_port_pkg::*;

    always_comb begin
        if (interleaved) begin
            orderedLow = startLow ^ beat;
        end else begin
            orderedLow = startLow + beat;
        end
    end

endmodule : burst_sequencer

// ### sram_cell_array.sv
// storage array with per-lane write and combinational read
`timescale 1ns/10ps
module sram_cell_array #(
    parameter int LANES  = 4,
    parameter int ADDR_W = 19,
    parameter int DEPTH  = 524288
) (
    input  wire logic                                 clk,
    input  wire logic                                 writeEn,
    input  wire logic [LANES-1:0]                     writeLanes,
    input  wire logic [ADDR_W-1:0]                    writeAddr,
    input  wire logic [LANES*sram_port_pkg::LANE_BITS-1:0] writeData,
    input  wire logic [ADDR_W-1:0]                    readAddr,
    output logic      [LANES*sram_port_pkg::LANE_BITS-1:0] readData
);
    import sram_port_pkg::*;

    // no reset: contents are undefined until written
    logic [LANES*LANE_BITS-1:0] cells [0:DEPTH-1];

    assign readData = cells[readAddr];

    // ------------------------------------------------------------
    // lane writes
    // ------------------------------------------------------------
    // one process for all lanes, so the array keeps a single writer
    always_ff @(posedge clk) begin
        for (int g = 0; g < LANES; g++) begin
            if (writeEn && writeLanes[g]) begin
                cells[writeAddr][g*LANE_BITS +: LANE_BITS] <=
                    writeData[g*LANE_BITS +: LANE_BITS];
            end
        end
    end

endmodule : sram_cell_array

// ### pipelined_burst_sram_port.sv
// pipelined burst sram device: input registers, burst counter, data pipeline, array
`timescale 1ns/10ps
module pipelined_burst_sram_port #(
    parameter bit WIDE_ORG = 1'b1,
    parameter int LANES    = WIDE_ORG ? sram_port_pkg::LANES_WIDE : sram_port_pkg::LANES_NARROW,
    parameter int ADDR_W   = WIDE_ORG ? sram_port_pkg::ADDR_W_WIDE
                                      : sram_port_pkg::ADDR_W_NARROW,
    parameter int DEPTH    = WIDE_ORG ? sram_port_pkg::DEPTH_WIDE : sram_port_pkg::DEPTH_NARROW
) (
    input  wire logic                    clk,
    input  wire logic                    rstn,
    input  wire logic                    clockSuspendN,
    input  wire logic                    advanceOrLoad,
    input  wire logic                    deviceSelectAN,
    input  wire logic                    deviceSelectB,
    input  wire logic                    deviceSelectCN,
    input  wire logic                    readWriteN,
    input  wire logic [ADDR_W-3:0]       upperAddress,
    input  wire logic                    burstAddrBit1,
    input  wire logic                    burstAddrBit0,
    input  wire logic                    byteLane0WriteN,
    input  wire logic                    byteLane1WriteN,
    input  wire logic                    byteLane2WriteN,
    input  wire logic                    byteLane3WriteN,
    input  wire logic                    burstOrderStrap,
    input  wire logic                    outputEnableN,
    input  wire logic                    sleepRequest,
    input  wire logic [LANES*8-1:0]      dataLanesIn,
    input  wire logic [LANES-1:0]        parityLanesIn,
    output logic      [LANES*8-1:0]      dataLanesOut,
    output logic      [LANES-1:0]        parityLanesOut,
    output logic                         dataOeN
);
    import sram_port_pkg::*;

    localparam int DATA_W = LANES * LANE_BITS;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    // ------------------------------------------------------------
    // input qualification
    // ------------------------------------------------------------
    logic                advance;
    logic                selected;
    logic                loadCycle;
    logic                stepCycle;
    logic                startAccess;
    logic [ADDR_W-1:0]   extAddr;
    logic [MAX_LANES-1:0] allLanesN;
    logic [LANES-1:0]    lanesN;

    // suspend masks the clock for every register below
    assign advance   = !clockSuspendN ? 1'b1 : 1'b0;
    assign selected  = device_selected(deviceSelectAN, deviceSelectB,
                                       deviceSelectCN);
    assign extAddr   = {upperAddress, burstAddrBit1, burstAddrBit0};
    assign allLanesN = {byteLane3WriteN, byteLane2WriteN,
                        byteLane1WriteN, byteLane0WriteN};
    // narrow organization simply never looks at lanes two and three
    assign lanesN    = allLanesN[LANES-1:0];

    // ------------------------------------------------------------
    // burst counter state
    // ------------------------------------------------------------
    burst_state_t      burstState_reg;
    burst_state_t      burstState_next;
    logic [ADDR_W-1:0] baseAddr_reg;
    logic [ADDR_W-1:0] baseAddr_next;
    logic [1:0]        beat_reg;
    logic [1:0]        beat_next;
    logic              burstWrite_reg;
    logic              burstWrite_next;
    logic [1:0]        stepBeat;
    logic [1:0]        orderedLow;

    assign loadCycle   = advance && !advanceOrLoad;
    assign stepCycle   = advance && advanceOrLoad && (burstState_reg == BURST_RUN);
    assign startAccess = loadCycle && selected && !sleepRequest;
    assign stepBeat    = beat_reg + 2'h1;

    // strap read straight through, no clock involved
    burst_sequencer uSequencer (
        .startLow    (baseAddr_reg[1:0]),
        .beat        (stepBeat),
        .interleaved (burstOrderStrap),
        .orderedLow  (orderedLow)
    );

    always_comb begin
        burstState_next = burstState_reg;
        baseAddr_next   = baseAddr_reg;
        beat_next       = beat_reg;
        burstWrite_next = burstWrite_reg;
        if (loadCycle) begin
            if (startAccess) begin
                burstState_next = BURST_RUN;
                baseAddr_next   = extAddr;
                beat_next       = BEAT_RESET;
                burstWrite_next = !readWriteN;
            end else begin
                burstState_next = BURST_IDLE;
            end
        end else if (stepCycle) begin
            beat_next = stepBeat;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            burstState_reg <= BURST_IDLE;
            baseAddr_reg   <= '0;
            beat_reg       <= BEAT_RESET;
            burstWrite_reg <= 1'h0;
        end else begin
            burstState_reg <= burstState_next;
            baseAddr_reg   <= baseAddr_next;
            beat_reg       <= beat_next;
            burstWrite_reg <= burstWrite_next;
        end
    end

    a_deselect_stops: assert property (loadCycle && !selected |=>
        burstState_reg == BURST_IDLE) else $error("burst survived a deselect");
    a_burst_step: assert property (stepCycle |=>
        beat_reg == $past(beat_reg) + 2'h1) else $error("burst counter did not step");
    a_burst_order: assert property (stepCycle && !burstOrderStrap |->
        orderedLow == baseAddr_reg[1:0] + beat_reg + 2'h1)
        else $error("linear burst address wrong");
    a_suspend_burst: assert property (!advance |=> $stable(beat_reg) &&
        $stable(burstState_reg)) else $error("burst state moved in suspend");

    // ------------------------------------------------------------
    // access pipeline: stage a is the sampled command, stage b loads read data,
    // stage c takes write data, so both directions share one bus slot
    // ------------------------------------------------------------
    logic              issueValid;
    logic              issueWrite;
    logic [ADDR_W-1:0] issueAddr;
    logic              validA_reg;
    logic              validA_next;
    logic              writeA_reg;
    logic              writeA_next;
    logic [ADDR_W-1:0] addrA_reg;
    logic [ADDR_W-1:0] addrA_next;
    logic [LANES-1:0]  lanesNA_reg;
    logic [LANES-1:0]  lanesNA_next;
    logic              validB_reg;
    logic              validB_next;
    logic              writeB_reg;
    logic              writeB_next;
    logic [ADDR_W-1:0] addrB_reg;
    logic [ADDR_W-1:0] addrB_next;
    logic [LANES-1:0]  lanesNB_reg;
    logic [LANES-1:0]  lanesNB_next;
    logic              validC_reg;
    logic              validC_next;
    logic              writeC_reg;
    logic              writeC_next;
    logic [ADDR_W-1:0] addrC_reg;
    logic [ADDR_W-1:0] addrC_next;
    logic [LANES-1:0]  lanesNC_reg;
    logic [LANES-1:0]  lanesNC_next;

    always_comb begin
        issueValid = stepCycle;
        issueWrite = burstWrite_reg;
        issueAddr  = {baseAddr_reg[ADDR_W-1:2], orderedLow};
        if (loadCycle) begin
            issueValid = startAccess;
            issueWrite = !readWriteN;
            issueAddr  = extAddr;
        end
    end

    // no bubble between stages, so any read/write mix streams at full rate
    always_comb begin
        validA_next  = validA_reg;
        writeA_next  = writeA_reg;
        addrA_next   = addrA_reg;
        lanesNA_next = lanesNA_reg;
        validB_next  = validB_reg;
        writeB_next  = writeB_reg;
        addrB_next   = addrB_reg;
        lanesNB_next = lanesNB_reg;
        validC_next  = validC_reg;
        writeC_next  = writeC_reg;
        addrC_next   = addrC_reg;
        lanesNC_next = lanesNC_reg;
        if (advance) begin
            validA_next  = issueValid;
            writeA_next  = issueWrite;
            addrA_next   = issueAddr;
            lanesNA_next = lanesN;
            validB_next  = validA_reg;
            writeB_next  = writeA_reg;
            addrB_next   = addrA_reg;
            lanesNB_next = lanesNA_reg;
            validC_next  = validB_reg;
            writeC_next  = writeB_reg;
            addrC_next   = addrB_reg;
            lanesNC_next = lanesNB_reg;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            validA_reg  <= VALID_RESET;
            writeA_reg  <= 1'h0;
            addrA_reg   <= '0;
            lanesNA_reg <= '1;
            validB_reg  <= VALID_RESET;
            writeB_reg  <= 1'h0;
            addrB_reg   <= '0;
            lanesNB_reg <= '1;
            validC_reg  <= VALID_RESET;
            writeC_reg  <= 1'h0;
            addrC_reg   <= '0;
            lanesNC_reg <= '1;
        end else begin
            validA_reg  <= validA_next;
            writeA_reg  <= writeA_next;
            addrA_reg   <= addrA_next;
            lanesNA_reg <= lanesNA_next;
            validB_reg  <= validB_next;
            writeB_reg  <= writeB_next;
            addrB_reg   <= addrB_next;
            lanesNB_reg <= lanesNB_next;
            validC_reg  <= validC_next;
            writeC_reg  <= writeC_next;
            addrC_reg   <= addrC_next;
            lanesNC_reg <= lanesNC_next;
        end
    end

    a_suspend_pipe: assert property (!advance |=> $stable(validA_reg) &&
        $stable(validB_reg) && $stable(addrB_reg) && $stable(validC_reg))
        else $error("pipeline moved in suspend");

    // ------------------------------------------------------------
    // array and data path
    // ------------------------------------------------------------
    logic              memWriteEn;
    logic [DATA_W-1:0] memWriteData;
    logic [DATA_W-1:0] memReadData;
    logic [DATA_W-1:0] readData_reg;
    logic [DATA_W-1:0] readData_next;
    logic              drive_reg;
    logic              drive_next;

    // the controller drives write data two cycles after its address, in the
    // same slot where read data would stand, so it is taken at the third edge
    assign memWriteEn = advance && validC_reg && writeC_reg;

    for (genvar g = 0; g < LANES; g++) begin : gPack
        assign memWriteData[g*LANE_BITS +: LANE_BITS] =
            {parityLanesIn[g], dataLanesIn[g*LANE_DATA_BITS +: LANE_DATA_BITS]};
        assign dataLanesOut[g*LANE_DATA_BITS +: LANE_DATA_BITS] =
            readData_reg[g*LANE_BITS +: LANE_DATA_BITS];
        assign parityLanesOut[g] = readData_reg[g*LANE_BITS + LANE_DATA_BITS];
    end

    sram_cell_array #(
        .LANES  (LANES),
        .ADDR_W (ADDR_W),
        .DEPTH  (DEPTH)
    ) uArray (
        .clk        (clk),
        .writeEn    (memWriteEn),
        .writeLanes (~lanesNC_reg),
        .writeAddr  (addrC_reg),
        .writeData  (memWriteData),
        .readAddr   (addrB_reg),
        .readData   (memReadData)
    );

    always_comb begin
        readData_next = readData_reg;
        drive_next    = drive_reg;
        if (advance) begin
            drive_next = validB_reg && !writeB_reg;
            if (validB_reg && !writeB_reg) begin
                readData_next = memReadData;
                // a write landing on this same edge would otherwise be missed
                for (int g = 0; g < LANES; g++) begin
                    if (memWriteEn && !lanesNC_reg[g] && addrC_reg == addrB_reg) begin
                        readData_next[g*LANE_BITS +: LANE_BITS] =
                            memWriteData[g*LANE_BITS +: LANE_BITS];
                    end
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            readData_reg <= '0;
            drive_reg    <= DRIVE_RESET;
        end else begin
            readData_reg <= readData_next;
            drive_reg    <= drive_next;
        end
    end

    // output enable gates the pin asynchronously on top of the pipeline
    assign dataOeN = !(drive_reg && !outputEnableN);

    sequence s_read_start;
        startAccess && readWriteN;
    endsequence
    sequence s_write_start;
        startAccess && !readWriteN;
    endsequence
    sequence s_two_steps;
        advance ##1 advance ##1 advance;
    endsequence

    a_read_drives: assert property (s_read_start ##0 s_two_steps |=>
        drive_reg) else $error("read data not driven two cycles later");
    a_write_quiet: assert property (s_write_start ##0 s_two_steps |=>
        !drive_reg) else $error("bus driven in write data cycle");
    a_deselect_release: assert property (loadCycle && !selected ##0 s_two_steps |=>
        !drive_reg) else $error("bus not released after deselect");
    a_pending_write: assert property (validA_reg && writeA_reg && advance ##1 advance
        ##1 advance |-> memWriteEn) else $error("pending write dropped");
    a_oe_async: assert property (outputEnableN |-> dataOeN)
        else $error("output enable did not disable bus");

endmodule : pipelined_burst_sram_port

// ### burst_sram_host.sv
// controller model: drives write data two cycles after each write beat
`timescale 1ns/10ps
module burst_sram_host (
    input  wire logic        clk,
    input  wire logic        clockSuspendN,
    input  wire logic        advanceOrLoad,
    input  wire logic        selected,
    input  wire logic        readWriteN,
    input  wire logic [35:0] cmdData,
    output logic      [35:0] hostWord,
    output logic             hostDrive
);
    logic        inBurst = 1'b0, isWrite = 1'b0;
    logic [36:0] stage1 = '0, stage2 = '0, stage3 = '0;
    logic [35:0] lastWord = '0;
    always @(posedge clk) begin
        if (!clockSuspendN) begin
            if (!advanceOrLoad) begin
                inBurst <= selected;
                isWrite <= !readWriteN;
            end
            // a write beat is a selected write load or an advance in a write burst
            stage1[36] <= advanceOrLoad ? inBurst && isWrite : selected && !readWriteN;
            stage1[35:0] <= cmdData;
            stage2 <= stage1;
            stage3 <= stage2;
            if (stage3[36])
                lastWord <= stage3[35:0];
        end
    end
    // released bus shows the inverse of the last word, never a stale copy
    assign hostDrive = stage3[36];
    assign hostWord  = hostDrive ? stage3[35:0] : ~lastWord;
endmodule : burst_sram_host

// ### pipelined_burst_sram_port_bench.sv
// self-checking bench for the pipelined burst sram port
`timescale 1ns/10ps
module pipelined_burst_sram_port_bench;
    import sram_port_pkg::*;
    logic        clk = 1'b0, rstn = 1'b0, suspendN = 1'b0, advLoad = 1'b0;
    logic        selAN = 1'b1, selB = 1'b0, selCN = 1'b1, rwN = 1'b1;
    logic        strap = 1'b0, oeN = 1'b0, sleep = 1'b0;
    logic [18:0] addr = 19'h0;
    logic [3:0]  laneN = 4'hf;
    logic [35:0] cmdData = 36'h0;
    logic [31:0] dOut;
    logic [3:0]  pOut;
    logic        dataOeN, hostDrive, selected;
    logic [35:0] hostWord, busWord;
    int          n_errors = 0;
    int          check_count = 0;
    always #20 clk = ~clk;
    assign busWord  = dataOeN ? hostWord : {pOut, dOut};
    assign selected = !selAN && selB && !selCN && !sleep;
    pipelined_burst_sram_port #(.WIDE_ORG(1'b1)) DUT (
        .clk(clk), .rstn(rstn), .clockSuspendN(suspendN), .advanceOrLoad(advLoad),
        .deviceSelectAN(selAN), .deviceSelectB(selB), .deviceSelectCN(selCN), .readWriteN(rwN),
        .upperAddress(addr[18:2]), .burstAddrBit1(addr[1]), .burstAddrBit0(addr[0]),
        .byteLane0WriteN(laneN[0]), .byteLane1WriteN(laneN[1]), .byteLane2WriteN(laneN[2]),
        .byteLane3WriteN(laneN[3]), .burstOrderStrap(strap), .outputEnableN(oeN),
        .sleepRequest(sleep), .dataLanesIn(busWord[31:0]), .parityLanesIn(busWord[35:32]),
        .dataLanesOut(dOut), .parityLanesOut(pOut), .dataOeN(dataOeN));
    burst_sram_host HOST (
        .clk(clk), .clockSuspendN(suspendN), .advanceOrLoad(advLoad), .selected(selected),
        .readWriteN(rwN), .cmdData(cmdData), .hostWord(hostWord), .hostDrive(hostDrive));
    task automatic check(input string what, input logic [35:0] exp, input logic [35:0] seen);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic bus(input logic oe, input logic [35:0] d);
        check("dataOeN", {35'h0, oe}, {35'h0, dataOeN});
        if (!oe)
            check("read word", d, busWord);
    endtask : bus
    // sel: 0 selected, 1..3 one select inactive, 4 sleep
    task automatic step(input int sel, input logic ld, input logic w, input logic [18:0] a,
                        input logic [3:0] ln, input logic [35:0] wd);
        {advLoad, selAN, selB, selCN, sleep} = {!ld, sel == 1, sel != 2, sel == 3, sel == 4};
        {rwN, addr, laneN, cmdData} = {w, a, ln, wd};
        @(negedge clk);
    endtask : step
    task automatic wr(input logic [18:0] a, input logic [35:0] d);
        step(0, 1'b1, 1'b0, a, 4'h0, d);
    endtask : wr
    task automatic rd(input logic [18:0] a);
        step(0, 1'b1, 1'b1, a, 4'hf, 36'h0);
    endtask : rd
    task automatic adv();
        step(0, 1'b0, 1'b1, 19'h0, 4'hf, 36'h0);
    endtask : adv
    task automatic idle();
        step(1, 1'b1, 1'b1, 19'h0, 4'hf, 36'h0);
    endtask : idle
    function automatic logic [35:0] word(input int i);
        return {i[3:0], 32'hc0de0000 + 32'(i)};
    endfunction : word
    task automatic rdChk(input logic [18:0] a, input logic [35:0] d);
        idle();
        idle();
        rd(a);
        bus(1'b1, 36'h0);
        idle();
        idle();
        bus(1'b0, d);
        idle();
        bus(1'b1, 36'h0);
    endtask : rdChk
    task automatic t_single();
        wr(19'h10, 36'h9_a5a5_1234);
        wr(19'h20, 36'h0_1122_3344);
        step(0, 1'b1, 1'b0, 19'h20, 4'b1010, 36'hf_aabb_ccdd);
        rdChk(19'h10, 36'h9_a5a5_1234);
        rdChk(19'h20, 36'h5_11bb_33dd);
        rd(19'h10);
        idle();
        idle();
        oeN = 1'b1;
        #1 bus(1'b1, 36'h0);
        oeN = 1'b0;
        #1 bus(1'b0, 36'h9_a5a5_1234);
        $display("single access test done");
    endtask : t_single
    task automatic t_burst();
        logic [1:0] low;
        for (int i = 0; i < 4; i++)
            wr(19'h40 + 19'(i), word(i));
        for (int m = 0; m < 2; m++) begin
            for (int s = 1; s < 4; s++) begin
                idle();
                idle();
                strap = m[0];
                for (int j = 0; j < 6; j++) begin
                    if (j == 0)
                        rd(19'h40 + 19'(s));
                    else if (j < 4)
                        adv();
                    else
                        idle();
                    low = m[0] ? 2'(s ^ (j - 2)) : 2'(s + j - 2);
                    if (j > 1)
                        bus(1'b0, word(int'(low)));
                end
            end
        end
        $display("burst order test done");
    endtask : t_burst
    task automatic t_b2b();
        wr(19'h50, 36'h1_5050_5050);
        rd(19'h41);
        wr(19'h51, 36'h2_5151_5151);
        bus(1'b1, 36'h0);
        rd(19'h42);
        bus(1'b0, word(1));
        idle();
        bus(1'b1, 36'h0);
        idle();
        bus(1'b0, word(2));
        rdChk(19'h50, 36'h1_5050_5050);
        rdChk(19'h51, 36'h2_5151_5151);
        $display("back to back test done");
    endtask : t_b2b
    task automatic t_suspend();
        rd(19'h43);
        suspendN = 1'b1;
        idle();
        bus(1'b1, 36'h0);
        suspendN = 1'b0;
        idle();
        idle();
        bus(1'b0, word(3));
        suspendN = 1'b1;
        wr(19'h43, 36'h0);
        bus(1'b0, word(3));
        suspendN = 1'b0;
        idle();
        bus(1'b1, 36'h0);
        rdChk(19'h43, word(3));
        $display("clock suspend test done");
    endtask : t_suspend
    task automatic t_desel();
        strap = 1'b0;
        for (int k = 1; k < 5; k++) begin
            rd(19'h40);
            adv();
            step(k, 1'b1, 1'b0, 19'h42, 4'h0, 36'h0);
            bus(1'b0, word(0));
            adv();
            bus(1'b0, word(1));
            adv();
            bus(1'b1, 36'h0);
            idle();
            bus(1'b1, 36'h0);
            idle();
        end
        rdChk(19'h42, word(2));
        $display("deselect test done");
    endtask : t_desel
    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : summarize
    always @(negedge clk)
        if (rstn && hostDrive)
            check("bus owner", 36'h1, {35'h0, dataOeN});
    initial begin
        repeat (20) @(posedge clk);
        @(negedge clk);
        rstn = 1'b1;
        bus(1'b1, 36'h0);
        t_single();
        t_burst();
        t_b2b();
        t_suspend();
        t_desel();
        summarize();
    end
    // tests take about 155 cycles; allow over six times that
    initial begin
        #40000;
        n_errors++;
        summarize();
    end
endmodule : pipelined_burst_sram_port_bench
